// >>> rtl/qos_sched_pkg.sv
// Shared constants for the port traffic control block
// Assumes a 250 MHz clock and a 32-bit APB register bus

package qos_sched_pkg;

   // ***********************************************
   // Widths
   // ***********************************************
   localparam int ADDR_W = 8;
   localparam int LEN_W = 11;
   localparam int STAMP_W = 9;
   localparam int CRED_W = 24;
   localparam int NCLASS = 4;

   // ***********************************************
   // Register offsets
   // ***********************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_RATE = 8'h04;
   localparam logic [7:0] OFF_FLOOD = 8'h08;
   localparam logic [7:0] OFF_MAP = 8'h0c;
   localparam logic [7:0] OFF_QUOTA = 8'h10;
   localparam logic [7:0] OFF_LAT = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // ***********************************************
   // Field positions
   // ***********************************************
   localparam int CTRL_FLOOD_LSB = 0;
   localparam int CTRL_PRIO_LSB = 8;
   localparam int RATE_RX_LSB = 0;
   localparam int RATE_TX_LSB = 8;
   localparam int ST_EMPTY_LSB = 0;
   localparam int ST_FLOOD_LSB = 4;
   localparam int ST_CLASS_LSB = 8;
   localparam int ST_STATE_LSB = 12;

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic [2:0] RST_FLOOD_EN = 3'h0;
   localparam logic [2:0] RST_PRIO = 3'h0;
   localparam logic [6:0] RST_UNITS = 7'h00;
   localparam logic [15:0] RST_THRESH = 16'h01f4;
   localparam logic [15:0] RST_MAP = 16'hfa50;
   localparam logic [31:0] RST_QUOTA = 32'h0a0a0a0a;
   localparam logic [31:0] RST_LAT = 32'h0a0a0a0a;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLOCK_MHZ = 250;
   localparam int TICK_US = 16;
   localparam int TICK_CYCLES = TICK_US * CLOCK_MHZ;
   localparam int RATE_WINDOW_US = 1000;
   localparam int FLOOD_WINDOW_US = 1000000;

   // Scheduler states
   typedef enum logic [1:0] {
      ST_PICK = 2'b00,
      ST_HOLD = 2'b01,
      ST_SEND = 2'b11
   } sched_state_t;

endpackage

// >>> rtl/class_queue.sv
// Descriptor queue for one traffic class, head read from a register
// Assumes DEPTH is a power of two, push only when not full, pop only
// while head_valid is high

`timescale 1ns/10ps
module class_queue #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head,
   output logic head_valid,
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;

   // Storage, no reset needed
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= push_data;
      end
      head <= mem[rd_ptr];
   end

   // Pointers and fill level
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         head_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
         // Head is stale for one cycle after a pop or first push
         head_valid <= (count != '0) && !pop;
      end
   end

   assign full = (count == (AW+1)'(DEPTH));
   assign empty = (count == '0);
endmodule

// >>> rtl/port_qos_rate_scheduler.sv
// Per-port rate limits, flood suppression, priority and class scheduling
// Assumes APB master, frame source and frame sink all on clock

`timescale 1ns/10ps
module port_qos_rate_scheduler
   import qos_sched_pkg::*;
#(
   parameter int UNIT_BYTES = 64,
   parameter int RATE_WINDOW_CYCLES = RATE_WINDOW_US * CLOCK_MHZ,
   parameter int FLOOD_WINDOW_CYCLES = FLOOD_WINDOW_US * CLOCK_MHZ,
   parameter int QUEUE_DEPTH = 16
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic [LEN_W-1:0] rx_len,
   input wire logic rx_broadcast,
   input wire logic rx_multicast,
   input wire logic rx_unknown_destination,
   input wire logic rx_tagged,
   input wire logic [2:0] rx_prio,
   output logic rx_accept,
   output logic rx_drop,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [LEN_W-1:0] tx_len,
   output logic [1:0] tx_class
);
   localparam int QW = STAMP_W + LEN_W;

   logic [2:0] flood_en;
   logic [2:0] def_prio;
   logic [6:0] rx_units;
   logic [6:0] tx_units;
   logic [15:0] thresh;
   logic [15:0] prio_map;
   logic [31:0] quota;
   logic [31:0] latency;
   logic hit;
   logic [31:0] rd_mux;
   logic wr_en;
   sched_state_t state;
   logic [1:0] cur_class;
   logic [7:0] sent;
   logic [3:0] q_empty;
   logic [3:0] q_full;
   logic [3:0] q_hv;
   logic [3:0] q_pop;
   logic [3:0] q_push;
   logic [QW-1:0] q_head [NCLASS];
   logic [3:0] overdue;
   logic [2:0] flood_blk;

   // ***********************************************
   // APB register access
   // ***********************************************

   // Read mux and address decode
   always_comb begin
      hit = 1'b1;
      rd_mux = '0;
      case (paddr)
         OFF_CTRL: begin
            rd_mux[CTRL_FLOOD_LSB +: 3] = flood_en;
            rd_mux[CTRL_PRIO_LSB +: 3] = def_prio;
         end
         OFF_RATE: begin
            rd_mux[RATE_RX_LSB +: 7] = rx_units;
            rd_mux[RATE_TX_LSB +: 7] = tx_units;
         end
         OFF_FLOOD: rd_mux[15:0] = thresh;
         OFF_MAP: rd_mux[15:0] = prio_map;
         OFF_QUOTA: rd_mux = quota;
         OFF_LAT: rd_mux = latency;
         OFF_STATUS: begin
            rd_mux[ST_EMPTY_LSB +: 4] = q_empty;
            rd_mux[ST_FLOOD_LSB +: 3] = flood_blk;
            rd_mux[ST_CLASS_LSB +: 2] = cur_class;
            rd_mux[ST_STATE_LSB +: 2] = state;
         end
         default: hit = 1'b0;
      endcase
   end

   assign wr_en = psel && penable && pready && pwrite && hit;

   // No wait state: answer registered in the setup cycle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata <= (psel && !penable && !pwrite) ? rd_mux : '0;
      end
   end

   // Configuration registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flood_en <= RST_FLOOD_EN;
         def_prio <= RST_PRIO;
         rx_units <= RST_UNITS;
         tx_units <= RST_UNITS;
         thresh <= RST_THRESH;
         prio_map <= RST_MAP;
         quota <= RST_QUOTA;
         latency <= RST_LAT;
      end else if (wr_en) begin
         case (paddr)
            OFF_CTRL: begin
               flood_en <= pwdata[CTRL_FLOOD_LSB +: 3];
               def_prio <= pwdata[CTRL_PRIO_LSB +: 3];
            end
            OFF_RATE: begin
               rx_units <= pwdata[RATE_RX_LSB +: 7];
               tx_units <= pwdata[RATE_TX_LSB +: 7];
            end
            OFF_FLOOD: thresh <= pwdata[15:0];
            OFF_MAP: prio_map <= pwdata[15:0];
            OFF_QUOTA: quota <= pwdata;
            OFF_LAT: latency <= pwdata;
            default: ;
         endcase
      end
   end

   // ***********************************************
   // Ingress classification and policing
   // ***********************************************
   logic [2:0] cat;
   logic [2:0] eff_prio;
   logic [1:0] rx_cls;
   logic [1:0] dflt_cls;
   logic flood_hit;
   logic [15:0] flood_cnt [3];
   logic [31:0] flood_win;
   logic flood_wrap;
   logic [31:0] rate_win;
   logic rate_wrap;
   logic [CRED_W-1:0] used_rx;
   logic [CRED_W-1:0] used_tx;
   logic [CRED_W-1:0] budget_rx;
   logic [CRED_W-1:0] budget_tx;
   logic rx_rate_ok;
   logic tx_rate_ok;
   logic rx_take;
   logic tx_commit;

   assign cat = {rx_unknown_destination, rx_multicast, rx_broadcast};
   // Untagged frames take the port default priority
   assign eff_prio = rx_tagged ? rx_prio : def_prio;
   assign rx_cls = prio_map[eff_prio*2 +: 2];
   assign dflt_cls = prio_map[def_prio*2 +: 2];
   assign flood_hit = |(cat & flood_en & flood_blk);

   // Budget per window; zero units leaves the direction unlimited
   assign budget_rx = CRED_W'(rx_units) * CRED_W'(UNIT_BYTES);
   assign budget_tx = CRED_W'(tx_units) * CRED_W'(UNIT_BYTES);
   assign rx_rate_ok = (rx_units == 7'h00) || (used_rx == '0) ||
      (used_rx + CRED_W'(rx_len) <= budget_rx);
   assign tx_rate_ok = (tx_units == 7'h00) || (used_tx == '0) ||
      (used_tx + CRED_W'(tx_len) <= budget_tx);
   assign rx_take = rx_valid && rx_rate_ok && !flood_hit && !q_full[rx_cls];
   assign tx_commit = (state == ST_HOLD) && tx_rate_ok;
   assign rate_wrap = (rate_win == 32'(RATE_WINDOW_CYCLES - 1));
   assign flood_wrap = (flood_win == 32'(FLOOD_WINDOW_CYCLES - 1));

   // Window counters for rate and flood measurement
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rate_win <= '0;
         flood_win <= '0;
      end else begin
         rate_win <= rate_wrap ? '0 : rate_win + 32'h1;
         flood_win <= flood_wrap ? '0 : flood_win + 32'h1;
      end
   end

   // Bytes used in the current window per direction
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         used_rx <= '0;
         used_tx <= '0;
      end else begin
         if (rate_wrap) begin
            used_rx <= '0;
            used_tx <= '0;
         end else begin
            if (rx_take) begin
               used_rx <= used_rx + CRED_W'(rx_len);
            end
            if (tx_commit) begin
               used_tx <= used_tx + CRED_W'(tx_len);
            end
         end
      end
   end

   // Per-category frame counters over one second, saturating
   for (genvar i = 0; i < 3; i++) begin : g_flood
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            flood_cnt[i] <= '0;
         end else if (flood_wrap) begin
            flood_cnt[i] <= '0;
         end else if (rx_valid && cat[i] && flood_cnt[i] != 16'hffff) begin
            flood_cnt[i] <= flood_cnt[i] + 16'h1;
         end
      end
      assign flood_blk[i] = (flood_cnt[i] >= thresh);
   end

   // Ingress verdict pulses
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_accept <= 1'b0;
         rx_drop <= 1'b0;
      end else begin
         rx_accept <= rx_take;
         rx_drop <= rx_valid && !rx_take;
      end
   end

   // ***********************************************
   // Class queues and latency timer
   // ***********************************************
   logic [11:0] tick_div;
   logic [STAMP_W-1:0] now_tick;

   // Tick every 16 us, stamps queued frames
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tick_div <= '0;
         now_tick <= '0;
      end else if (tick_div == 12'(TICK_CYCLES - 1)) begin
         tick_div <= '0;
         now_tick <= now_tick + STAMP_W'(1);
      end else begin
         tick_div <= tick_div + 12'h1;
      end
   end

   for (genvar c = 0; c < NCLASS; c++) begin : g_queue
      logic [STAMP_W-1:0] age;
      logic [7:0] lim;
      assign q_push[c] = rx_take && (rx_cls == 2'(c));
      assign age = now_tick - q_head[c][LEN_W +: STAMP_W];
      assign lim = latency[c*8 +: 8];
      // Zero limit switches the age check off
      assign overdue[c] = q_hv[c] && (lim != 8'h00) &&
         (age >= STAMP_W'(lim));
      class_queue #(.WIDTH(QW), .DEPTH(QUEUE_DEPTH)) u_queue (
         .clock(clock),
         .resetn(resetn),
         .push(q_push[c]),
         .push_data({now_tick, rx_len}),
         .pop(q_pop[c]),
         .head(q_head[c]),
         .head_valid(q_hv[c]),
         .full(q_full[c]),
         .empty(q_empty[c])
      );
   end

   // ***********************************************
   // Scheduler
   // ***********************************************
   logic any_over;
   logic [1:0] over_cls;
   logic [7:0] quota_cur;
   logic serve_ok;
   logic do_pop;
   logic [1:0] pop_cls;

   // Highest overdue class wins over the quota order
   always_comb begin
      any_over = 1'b0;
      over_cls = 2'h0;
      for (int c = 0; c < NCLASS; c++) begin
         if (overdue[c]) begin
            any_over = 1'b1;
            over_cls = 2'(c);
         end
      end
   end

   assign quota_cur = quota[cur_class*8 +: 8];
   assign serve_ok = (quota_cur == 8'h00) || (sent < quota_cur);

   // Pop choice in the pick state
   always_comb begin
      do_pop = 1'b0;
      pop_cls = cur_class;
      if (state == ST_PICK) begin
         if (any_over) begin
            do_pop = 1'b1;
            pop_cls = over_cls;
         end else if (serve_ok && q_hv[cur_class]) begin
            do_pop = 1'b1;
         end
      end
      q_pop = 4'h0;
      q_pop[pop_cls] = do_pop;
   end

   // Class walk and transmit handshake
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= ST_PICK;
         cur_class <= 2'h3;
         sent <= '0;
         tx_valid <= 1'b0;
         tx_len <= '0;
         tx_class <= 2'h0;
      end else begin
         unique case (state)
            ST_PICK: begin
               if (do_pop) begin
                  tx_len <= q_head[pop_cls][LEN_W-1:0];
                  tx_class <= pop_cls;
                  state <= ST_HOLD;
                  if (!any_over && sent != 8'hff) begin
                     sent <= sent + 8'h1;
                  end
               end else if (serve_ok && !q_empty[cur_class]) begin
                  // Head register refilling; stay on this class
                  state <= ST_PICK;
               end else if (q_empty != 4'hf) begin
                  cur_class <= cur_class - 2'h1;
                  sent <= '0;
               end else begin
                  cur_class <= 2'h3;
                  sent <= '0;
               end
            end
            ST_HOLD: begin
               if (tx_commit) begin
                  tx_valid <= 1'b1;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (tx_ready) begin
                  tx_valid <= 1'b0;
                  state <= ST_PICK;
               end
            end
         endcase
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_rx_over_budget: assert property (
      (rx_valid && rx_units != 7'h00 && used_rx != '0 && !rate_wrap &&
       used_rx + CRED_W'(rx_len) > budget_rx) |=> rx_drop && !rx_accept)
      else $error("receive frame over budget was accepted");

   a_tx_over_budget: assert property (
      (state == ST_HOLD && tx_units != 7'h00 && used_tx != '0 &&
       used_tx + CRED_W'(tx_len) > budget_tx) |=> !tx_valid)
      else $error("transmit started over budget");

   a_flood_off: assert property (
      (rx_valid && rx_units == 7'h00 && (cat & flood_en) == 3'h0 &&
       !q_full[rx_cls]) |=> rx_accept)
      else $error("frame dropped with flood checks off");

   a_flood_drop: assert property (
      (rx_valid && rx_broadcast && flood_en[0] && flood_cnt[0] >= thresh)
      |=> rx_drop && !rx_accept)
      else $error("broadcast beyond threshold not dropped");

   a_default_prio: assert property (
      (rx_take && !rx_tagged) |=> !q_empty[$past(dflt_cls)])
      else $error("untagged frame not queued at default class");

   a_quota_spent: assert property (
      (state == ST_PICK && !any_over && quota_cur != 8'h00 &&
       sent >= quota_cur && q_empty != 4'hf)
      |=> cur_class == $past(cur_class) - 2'h1 && state == ST_PICK)
      else $error("class kept after quota spent");

   a_quota_zero: assert property (
      (state == ST_PICK && !any_over && quota_cur == 8'h00 &&
       !q_empty[cur_class]) |=> cur_class == $past(cur_class))
      else $error("zero quota class left while not empty");

   a_latency_first: assert property (
      (state == ST_PICK && any_over)
      |=> state == ST_HOLD && tx_class == $past(over_cls))
      else $error("overdue frame not sent first");

   a_timer_off: assert property (
      (state == ST_PICK && overdue == 4'h0 && serve_ok && q_hv[cur_class])
      |=> tx_class == $past(cur_class) ##1 state != ST_PICK)
      else $error("quota order broken without overdue frame");
endmodule

// >>> verif/station_sink.sv
// Frame sink that stands for the neighbouring station on the transmit side
// Assumes the tx handshake runs on clock; logs the class of the first 16 frames taken
`timescale 1ns/10ps
module station_sink (
   input wire logic clock,
   input wire logic resetn,
   input wire logic stall,
   input wire logic slow,
   input wire logic clear,
   input wire logic tx_valid,
   input wire logic [1:0] tx_class,
   output logic tx_ready
);
   logic [1:0] log_class [0:15];
   int n_taken;

   // Ready falls while stalled and comes every other cycle when slow
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= !stall && (!slow || !tx_ready);
      end
   end

   // A frame is taken at an edge with valid and ready both high
   always_ff @(posedge clock) begin
      if (clear) begin
         n_taken <= 0;
      end else if (tx_valid && tx_ready && n_taken < 16) begin
         log_class[n_taken] <= tx_class;
         n_taken <= n_taken + 1;
      end
   end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the port traffic control block
// Assumes the design package; a sink model takes the transmit side
`timescale 1ns/10ps
module tb_top;
   import qos_sched_pkg::*;
   logic clock, resetn, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rx_valid, rx_broadcast, rx_multicast, rx_unknown_destination;
   logic rx_tagged, rx_accept, rx_drop, tx_valid, tx_ready;
   logic [LEN_W-1:0] rx_len, tx_len;
   logic [2:0] rx_prio;
   logic [1:0] tx_class;
   logic stall, slow, clear;
   int errors, total_checks;

   // ***********************************************
   // Design and partner
   // ***********************************************
   port_qos_rate_scheduler #(.UNIT_BYTES(64), .RATE_WINDOW_CYCLES(2000),
      .FLOOD_WINDOW_CYCLES(5000), .QUEUE_DEPTH(16)) dut (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
      .rx_len(rx_len), .rx_broadcast(rx_broadcast),
      .rx_multicast(rx_multicast),
      .rx_unknown_destination(rx_unknown_destination),
      .rx_tagged(rx_tagged), .rx_prio(rx_prio), .rx_accept(rx_accept),
      .rx_drop(rx_drop), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_len(tx_len), .tx_class(tx_class));
   station_sink sink (.clock(clock), .resetn(resetn), .stall(stall),
      .slow(slow), .clear(clear), .tx_valid(tx_valid),
      .tx_class(tx_class), .tx_ready(tx_ready));

   // ***********************************************
   // Shared tasks
   // ***********************************************
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // APB transfer; holds the request until pready is seen high or 50 cycles pass
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // A wait that runs out counts as a mismatch
      check("pready", {31'h0, pready}, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One descriptor; cat is {unknown, multicast, broadcast}
   task automatic rx(input logic [10:0] len, input logic [2:0] cat,
      input logic tag, input logic [2:0] prio, input logic acc);
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_len <= len;
      {rx_unknown_destination, rx_multicast, rx_broadcast} <= cat;
      rx_tagged <= tag;
      rx_prio <= prio;
      @(posedge clock);
      rx_valid <= 1'b0;
      @(posedge clock);
      check("rx_accept", {31'h0, rx_accept}, {31'h0, acc});
      check("rx_drop", {31'h0, rx_drop}, {31'h0, !acc});
   endtask

   task automatic clr();
      @(posedge clock);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
   endtask

   // Waits, bounded, for n frames and compares the first four classes
   task automatic taken(input int n, input logic [7:0] exp);
      int k;
      logic [7:0] seen;
      k = 0;
      while (sink.n_taken < n && k < 20000) begin
         @(posedge clock);
         k++;
      end
      check("taken", sink.n_taken, n);
      // Slots past the n frames of this scenario read as zero
      for (int i = 0; i < 4; i++) begin
         seen[7-2*i -: 2] = (i < n) ? sink.log_class[i] : 2'h0;
      end
      check("classes", {24'h0, seen}, {24'h0, exp});
   endtask

   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic test_reset();
      apb(1'b0, OFF_CTRL, 32'h0);
      check("ctrl", rd, 32'h0);
      apb(1'b0, OFF_RATE, 32'h0);
      check("rate", rd, 32'h0);
      apb(1'b0, OFF_FLOOD, 32'h0);
      check("thresh", rd, 32'h000001f4);
      apb(1'b0, OFF_MAP, 32'h0);
      check("map", rd, 32'h0000fa50);
      apb(1'b0, OFF_QUOTA, 32'h0);
      check("quota", rd, 32'h0a0a0a0a);
      apb(1'b0, OFF_LAT, 32'h0);
      check("latency", rd, 32'h0a0a0a0a);
      apb(1'b1, 8'h1c, 32'hffffffff);
      apb(1'b0, 8'h1c, 32'h0);
      check("unmapped", {rd[31:1], err}, 32'h1);
      $display("test_reset done");
   endtask

   task automatic test_prio();
      clr();
      apb(1'b1, OFF_CTRL, 32'h00000500);
      apb(1'b1, OFF_MAP, 32'h0000f650);
      rx(11'd60, 3'b000, 1'b0, 3'd7, 1'b1);
      rx(11'd60, 3'b000, 1'b1, 3'd5, 1'b1);
      rx(11'd60, 3'b000, 1'b1, 3'd0, 1'b1);
      rx(11'd60, 3'b000, 1'b1, 3'd7, 1'b1);
      taken(4, 8'b01_01_00_11);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_MAP, 32'h0000fa50);
      $display("test_prio done");
   endtask

   task automatic test_flood();
      apb(1'b1, OFF_FLOOD, 32'h2);
      apb(1'b1, OFF_CTRL, 32'h1);
      rx(11'd64, 3'b001, 1'b0, 3'd0, 1'b1);
      rx(11'd64, 3'b001, 1'b0, 3'd0, 1'b1);
      rx(11'd64, 3'b001, 1'b0, 3'd0, 1'b0);
      rx(11'd64, 3'b001, 1'b0, 3'd0, 1'b0);
      rx(11'd64, 3'b010, 1'b0, 3'd0, 1'b1);
      apb(1'b1, OFF_CTRL, 32'h6);
      rx(11'd64, 3'b100, 1'b0, 3'd0, 1'b1);
      rx(11'd64, 3'b100, 1'b0, 3'd0, 1'b1);
      rx(11'd64, 3'b100, 1'b0, 3'd0, 1'b0);
      rx(11'd64, 3'b010, 1'b0, 3'd0, 1'b1);
      rx(11'd64, 3'b010, 1'b0, 3'd0, 1'b0);
      rx(11'd64, 3'b001, 1'b0, 3'd0, 1'b1);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_FLOOD, 32'h000001f4);
      $display("test_flood done");
   endtask

   task automatic test_rate();
      repeat (2100) @(posedge clock);
      apb(1'b1, OFF_RATE, 32'h2);
      rx(11'd60, 3'b000, 1'b0, 3'd0, 1'b1);
      rx(11'd60, 3'b000, 1'b0, 3'd0, 1'b1);
      rx(11'd60, 3'b000, 1'b0, 3'd0, 1'b0);
      apb(1'b1, OFF_RATE, 32'h0);
      rx(11'd60, 3'b000, 1'b0, 3'd0, 1'b1);
      repeat (2100) @(posedge clock);
      apb(1'b1, OFF_RATE, 32'h00000100);
      clr();
      rx(11'd60, 3'b000, 1'b0, 3'd0, 1'b1);
      rx(11'd60, 3'b000, 1'b0, 3'd0, 1'b1);
      repeat (20) @(posedge clock);
      check("tx_held", sink.n_taken, 32'd1);
      taken(2, 8'h00);
      check("tx_later", sink.n_taken, 32'd2);
      apb(1'b1, OFF_RATE, 32'h0);
      $display("test_rate done");
   endtask

   task automatic test_sched(input logic [31:0] q, input logic [31:0] l,
      input logic [2:0] p1, input int hold, input logic [7:0] exp);
      stall <= 1'b1;
      slow <= 1'b1;
      apb(1'b1, OFF_QUOTA, q);
      apb(1'b1, OFF_LAT, l);
      clr();
      rx(11'd60, 3'b000, 1'b1, 3'd7, 1'b1);
      rx(11'd60, 3'b000, 1'b1, p1, 1'b1);
      rx(11'd60, 3'b000, 1'b1, 3'd7, 1'b1);
      rx(11'd60, 3'b000, 1'b1, 3'd5, 1'b1);
      repeat (hold) @(posedge clock);
      stall <= 1'b0;
      taken(4, exp);
      slow <= 1'b0;
      $display("test_sched done");
   endtask

   // ***********************************************
   // Run control
   // ***********************************************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   initial begin
      repeat (60000) @(posedge clock);
      errors++;
      end_sim();
   end

   // Inputs at rest, reset for 16 cycles, then the scenarios
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {rx_valid, rx_len, rx_broadcast, rx_multicast} = '0;
      {rx_unknown_destination, rx_tagged, rx_prio} = '0;
      {stall, slow, clear} = '0;
      errors = 0;
      total_checks = 0;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      test_reset();
      test_prio();
      test_flood();
      test_rate();
      test_sched(32'h020a0a0a, 32'h0, 3'd7, 2, 8'b11_11_10_11);
      test_sched(32'h000a0a0a, 32'h1, 3'd0, 5000, 8'b11_00_11_10);
      end_sim();
   end
endmodule
